// file: hw/cgs_pkg.sv
// Constants shared by the counter second-gate, status and snapshot logic.
// Assumes a single 10 MHz clock and a plain word-addressed register port.
package cgs_pkg;

   // ----------------------------------------------------------------------
   // Register map, word offsets on the plain register port
   // ----------------------------------------------------------------------
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  OFS_SECOND_GATE = 4'h0;
   localparam logic [3:0]  OFS_STATUS      = 4'h1;
   localparam logic [3:0]  OFS_SW_SNAP     = 4'h2;
   localparam logic [3:0]  OFS_CONTROL     = 4'h3;
   localparam logic [3:0]  OFS_ACK         = 4'h4;
   localparam logic [3:0]  OFS_HW_SNAP     = 4'h5;

   // ----------------------------------------------------------------------
   // Second gate configuration fields
   // ----------------------------------------------------------------------
   localparam int          SG_INVERT_BIT   = 13;
   localparam int          SG_SEL_MSB      = 11;
   localparam int          SG_SEL_LSB      = 7;
   localparam int          SG_COMB_BIT     = 0;

   // Second gate select codes.
   localparam logic [4:0]  SEL_OWN_SRC     = 5'h00;
   localparam logic [4:0]  SEL_OWN_UPDOWN  = 5'h01;
   localparam logic [4:0]  SEL_UPDOWN_0    = 5'h02;
   localparam logic [4:0]  SEL_UPDOWN_7    = 5'h09;
   localparam logic [4:0]  SEL_NEIGH_SRC   = 5'h0a;
   localparam logic [4:0]  SEL_TRIG_0      = 5'h0b;
   localparam logic [4:0]  SEL_TRIG_6      = 5'h11;
   localparam logic [4:0]  SEL_NEIGH_OUT   = 5'h14;
   localparam logic [4:0]  SEL_PRIM_GATE   = 5'h1e;
   localparam logic [4:0]  SEL_LOW         = 5'h1f;

   // ----------------------------------------------------------------------
   // Status, control and acknowledge fields
   // ----------------------------------------------------------------------
   localparam int          ST_IRQ_BIT      = 15;
   localparam int          ST_TC_BIT       = 3;
   localparam int          CT_SAVE_FOLLOW  = 0;
   localparam int          CT_DMA_EN       = 1;
   localparam int          CT_MODE_LSB     = 2;
   localparam int          CT_PRIM_INV     = 4;
   localparam int          CT_ARM          = 5;
   localparam int          CT_TC_IE        = 6;
   localparam int          CT_DMA_IE       = 7;
   localparam int          ACK_TC_BIT      = 0;
   localparam int          ACK_DMA_BIT     = 1;

   // Gating modes.
   localparam logic [1:0]  MODE_NONE       = 2'h0;
   localparam logic [1:0]  MODE_LEVEL      = 2'h1;
   localparam logic [1:0]  MODE_RISE       = 2'h2;
   localparam logic [1:0]  MODE_FALL       = 2'h3;

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   localparam int          CNT_W           = 32;
   localparam logic [31:0] CNT_RESET       = 32'h0000_0000;
   localparam logic [31:0] CNT_TERMINAL    = 32'hffff_ffff;
   localparam int          PIN_W           = 20;

endpackage : cgs_pkg

// file: hw/cgs_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no bit relationship is kept.
`timescale 1ns/100ps
`default_nettype none
module cgs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output var  logic [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } cgs_sync_st_t;

   cgs_sync_st_t q;
   cgs_sync_st_t d;

   // The first stage is only read by the second stage.
   always_comb
   begin
      d      = q;
      d.meta = i_async;
      d.sync = q.meta;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         q <= '0;
      else
         q <= d;
   end

   assign o_sync = q.sync;

endmodule // cgs_sync
`default_nettype wire

// file: hw/cgs_save_regs.sv
// Software and hardware snapshot registers of one counter.
// Assumes the caller holds track and freeze low while DMA is enabled.
`timescale 1ns/100ps
`default_nettype none
module cgs_save_regs (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [31:0] i_value,
   input  wire logic        i_track,
   input  wire logic        i_freeze,
   input  wire logic        i_dma_en,
   input  wire logic        i_dma_save,
   output var  logic [31:0] o_sw,
   output var  logic [31:0] o_hw
);

   typedef struct packed {
      logic [31:0] sw;
      logic [31:0] hw;
      logic        to_sw;
   } cgs_save_st_t;

   cgs_save_st_t q;
   cgs_save_st_t d;

   always_comb
   begin
      d = q;
      if (i_dma_en && i_dma_save)
      begin
         // Saved values alternate, hardware register first.
         if (q.to_sw)
            d.sw = i_value; // RULE_16
         else
            d.hw = i_value;
         d.to_sw = !q.to_sw; // RULE_17
      end
      else if (i_freeze || i_track)
      begin
         d.sw = i_value; // RULE_14 RULE_15
      end
      if (!i_dma_en)
         d.to_sw = 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         q <= '0;
      else
         q <= d;
   end

   assign o_sw = q.sw;
   assign o_hw = q.hw;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   AST_DMA_ALTERNATE: assert property ( // RULE_17
      i_dma_en && i_dma_save && !q.to_sw |=> o_hw == $past(i_value) && $stable(o_sw) && q.to_sw)
      else $error("Hardware snapshot did not take its turn in the alternation.");

   AST_DMA_TO_SW: assert property ( // RULE_16
      i_dma_en && i_dma_save && q.to_sw |=> o_sw == $past(i_value) && $stable(o_hw) && !q.to_sw)
      else $error("Software snapshot did not take its turn in the alternation.");

endmodule // cgs_save_regs
`default_nettype wire

// file: hw/cgs_counter.sv
// Counter with second gate selection, combined start/stop gate,
// status flags and software/hardware snapshot registers.
// Assumes pins arrive asynchronously and the register master obeys a
// one-cycle strobe protocol with read data one cycle after the strobe.
//
// Operation
// (RULE_01) Bit 13 set inverts the selected second gate.
// (RULE_02) Bits 11 to 7 select the second gate signal.
// (RULE_03) Code 0 is own source pin, code 1 own up/down pin.
// (RULE_04) Codes 2 to 9 are up/down pins 0 to 7.
// (RULE_05) Code 10 is the neighbour counter's selected source.
// (RULE_06) Codes 11 to 17 are trigger lines 0 to 6; 20 neighbour output.
// (RULE_07) Code 30 is the processed primary gate; code 31 is constant low.
// (RULE_08) Combined mode: second gate edge asserts gate, primary edge deasserts it.
// (RULE_09) Level gating counts at once when armed with gate already high.
// (RULE_10) Software should invert both gates for complete pulse-width measurements.
// (RULE_11) Status bit 15 is terminal-count or DMA condition true and enabled.
// (RULE_12) Status bit 3 sets at terminal count, holds until acknowledged.
// (RULE_13) Writing the terminal-count acknowledge bit clears the flag.
// (RULE_14) After save-follow asserts, snapshot freezes on next source edge.
// (RULE_15) With save-follow clear, snapshot tracks the live count.
// (RULE_16) With DMA enabled, the snapshot serves as hardware save register.
// (RULE_17) In DMA mode saved values alternate between both snapshot registers.
// (RULE_18) Status register is read-only, 16 bits, other bits undefined.
// (RULE_19) Gating mode: 0 none, 1 level, 2 rising, 3 falling.
// (RULE_20) Without combined mode the primary gate is used unchanged.
// (RULE_21) Gate edges are sampled on selected source edges.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cgs_counter (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wr_data,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   output var  logic [31:0] o_rd_data,
   input  wire logic        i_src_pin,
   input  wire logic        i_updown_pin,
   input  wire logic [7:0]  i_updown_bus,
   input  wire logic        i_neighbour_source,
   input  wire logic [6:0]  i_trigger_bus_line,
   input  wire logic        i_neighbour_out,
   input  wire logic        i_gate_pin,
   output var  logic        o_counter_irq_flag,
   output var  logic        o_terminal_count_flag,
   output var  logic        o_eff_gate
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        second_gate_invert;
      logic [4:0]  second_gate_source_sel;
      logic        combined_gate_enable;
      logic        save_follow_ctl;
      logic        dma_transfer_en;
      logic [1:0]  gate_interpret_sel;
      logic        gate_invert_ctl;
      logic        arm;
      logic        tc_irq_en;
      logic        dma_irq_en;
      logic        src_prev;
      logic        prim_prev;
      logic        sec_prev;
      logic        gate_prev;
      logic        comb_gate;
      logic        eff_gate;
      logic        edge_run;
      logic [31:0] count;
      logic        terminal_count_flag;
      logic        dma_flag;
      logic        irq;
      logic        save_pend;
      logic [31:0] rd_data;
   } cgs_cnt_st_t;

   cgs_cnt_st_t q;
   cgs_cnt_st_t d;

   logic [cgs_pkg::PIN_W-1:0] pins_s;
   logic [31:0]               sw_snapshot_value;
   logic [31:0]               hw_snapshot_reg;
   logic                      src_edge;
   logic                      prim_gate;
   logic                      sec_raw;
   logic                      sec_gate;
   logic                      sec_rise;
   logic                      prim_rise;
   logic                      gate;
   logic                      gate_rise;
   logic                      gate_fall;
   logic                      act_edge;
   logic                      run;
   logic                      counting;
   logic                      tc_hit;
   logic                      save_evt;
   logic                      wr_cfg;
   logic                      wr_ctl;
   logic                      wr_ack;
   logic                      tc_ack;
   logic                      dma_ack;
   logic                      freeze;
   logic                      track;
   logic [15:0]               status_word;

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------
   cgs_sync #(
      .WIDTH (cgs_pkg::PIN_W)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_gate_pin, i_neighbour_out, i_trigger_bus_line,
                 i_neighbour_source, i_updown_bus, i_updown_pin, i_src_pin}),
      .o_sync  (pins_s)
   );

   // ----------------------------------------------------------------------
   // Gate selection
   // ----------------------------------------------------------------------
   always_comb
   begin
      src_edge  = pins_s[0] && !q.src_prev;
      prim_gate = pins_s[19] ^ q.gate_invert_ctl;
      sec_raw   = 1'b0;
      case (q.second_gate_source_sel) // RULE_02
         cgs_pkg::SEL_OWN_SRC:    sec_raw = pins_s[0]; // RULE_03
         cgs_pkg::SEL_OWN_UPDOWN: sec_raw = pins_s[1]; // RULE_03
         cgs_pkg::SEL_NEIGH_SRC:  sec_raw = pins_s[10]; // RULE_05
         cgs_pkg::SEL_NEIGH_OUT:  sec_raw = pins_s[18]; // RULE_06
         cgs_pkg::SEL_PRIM_GATE:  sec_raw = prim_gate; // RULE_07
         cgs_pkg::SEL_LOW:        sec_raw = 1'b0; // RULE_07
         default:
         begin
            if (q.second_gate_source_sel >= cgs_pkg::SEL_UPDOWN_0 &&
                q.second_gate_source_sel <= cgs_pkg::SEL_UPDOWN_7)
               sec_raw = pins_s[q.second_gate_source_sel]; // RULE_04
            else if (q.second_gate_source_sel >= cgs_pkg::SEL_TRIG_0 &&
                     q.second_gate_source_sel <= cgs_pkg::SEL_TRIG_6)
               sec_raw = pins_s[q.second_gate_source_sel]; // RULE_06
            else
               sec_raw = 1'b0;
         end
      endcase
      sec_gate  = sec_raw ^ q.second_gate_invert; // RULE_01
      sec_rise  = sec_gate && !q.sec_prev; // RULE_21
      prim_rise = prim_gate && !q.prim_prev; // RULE_21
      gate      = q.combined_gate_enable ? q.comb_gate : prim_gate; // RULE_20
      gate_rise = gate && !q.gate_prev;
      gate_fall = !gate && q.gate_prev;
      act_edge  = (q.gate_interpret_sel == cgs_pkg::MODE_RISE) ? gate_rise : gate_fall;
   end

   // ----------------------------------------------------------------------
   // Counting and save events
   // ----------------------------------------------------------------------
   always_comb
   begin
      case (q.gate_interpret_sel) // RULE_19
         cgs_pkg::MODE_NONE:  run = 1'b1;
         cgs_pkg::MODE_LEVEL: run = gate; // RULE_09
         cgs_pkg::MODE_RISE:  run = q.edge_run;
         cgs_pkg::MODE_FALL:  run = q.edge_run;
         default:             run = 1'b0;
      endcase
      counting = src_edge && q.arm && run;
      tc_hit   = counting && (q.count == cgs_pkg::CNT_TERMINAL);
      if (q.gate_interpret_sel == cgs_pkg::MODE_LEVEL)
         save_evt = src_edge && q.arm && gate_fall;
      else if (q.gate_interpret_sel == cgs_pkg::MODE_NONE)
         save_evt = 1'b0;
      else
         save_evt = src_edge && q.arm && act_edge && q.edge_run;
      freeze = q.save_pend && src_edge; // RULE_14
      track  = !q.save_follow_ctl; // RULE_15
   end

   // ----------------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      wr_cfg  = i_wr_en && (i_addr == cgs_pkg::OFS_SECOND_GATE);
      wr_ctl  = i_wr_en && (i_addr == cgs_pkg::OFS_CONTROL);
      wr_ack  = i_wr_en && (i_addr == cgs_pkg::OFS_ACK);
      tc_ack  = wr_ack && i_wr_data[cgs_pkg::ACK_TC_BIT];
      dma_ack = wr_ack && i_wr_data[cgs_pkg::ACK_DMA_BIT];
      status_word = 16'h0000; // RULE_18
      status_word[cgs_pkg::ST_IRQ_BIT] = q.irq; // RULE_11
      status_word[cgs_pkg::ST_TC_BIT]  = q.terminal_count_flag; // RULE_12
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      d          = q;
      d.src_prev = pins_s[0];
      if (wr_cfg)
      begin
         d.second_gate_invert     = i_wr_data[cgs_pkg::SG_INVERT_BIT];
         d.second_gate_source_sel = i_wr_data[cgs_pkg::SG_SEL_MSB:cgs_pkg::SG_SEL_LSB];
         d.combined_gate_enable   = i_wr_data[cgs_pkg::SG_COMB_BIT];
      end
      if (wr_ctl)
      begin
         d.save_follow_ctl    = i_wr_data[cgs_pkg::CT_SAVE_FOLLOW];
         d.dma_transfer_en    = i_wr_data[cgs_pkg::CT_DMA_EN];
         d.gate_interpret_sel = i_wr_data[cgs_pkg::CT_MODE_LSB +: 2];
         d.gate_invert_ctl    = i_wr_data[cgs_pkg::CT_PRIM_INV];
         d.arm                = i_wr_data[cgs_pkg::CT_ARM];
         d.tc_irq_en          = i_wr_data[cgs_pkg::CT_TC_IE];
         d.dma_irq_en         = i_wr_data[cgs_pkg::CT_DMA_IE];
         if (!i_wr_data[cgs_pkg::CT_ARM])
            d.edge_run = 1'b0;
      end
      // A fresh assertion of save-follow waits for the next source edge.
      if (freeze)
         d.save_pend = 1'b0;
      if (wr_ctl && i_wr_data[cgs_pkg::CT_SAVE_FOLLOW] && !q.save_follow_ctl)
         d.save_pend = 1'b1; // RULE_14
      else if (wr_ctl && !i_wr_data[cgs_pkg::CT_SAVE_FOLLOW])
         d.save_pend = 1'b0;
      if (src_edge)
      begin
         d.prim_prev = prim_gate; // RULE_21
         d.sec_prev  = sec_gate;
         d.gate_prev = gate;
         // Stop takes priority when both gates assert on one edge.
         if (prim_rise)
            d.comb_gate = 1'b0; // RULE_08
         else if (sec_rise)
            d.comb_gate = 1'b1; // RULE_08
         if (q.arm && (q.gate_interpret_sel == cgs_pkg::MODE_RISE ||
                       q.gate_interpret_sel == cgs_pkg::MODE_FALL) && act_edge)
            d.edge_run = !q.edge_run;
      end
      if (counting)
         d.count = q.count + 32'h0000_0001;
      // Hardware sets win over a simultaneous acknowledge.
      if (tc_ack)
         d.terminal_count_flag = 1'b0; // RULE_13
      if (tc_hit)
         d.terminal_count_flag = 1'b1; // RULE_12
      if (dma_ack)
         d.dma_flag = 1'b0;
      if (save_evt && q.dma_transfer_en)
         d.dma_flag = 1'b1;
      d.irq = (d.terminal_count_flag && d.tc_irq_en) || (d.dma_flag && d.dma_irq_en); // RULE_11
      d.eff_gate = d.combined_gate_enable ? d.comb_gate : d.gate_prev; // RULE_20
      d.rd_data = 32'h0000_0000;
      if (i_rd_en)
      begin
         case (i_addr)
            cgs_pkg::OFS_STATUS:  d.rd_data = {16'h0000, status_word};
            cgs_pkg::OFS_SW_SNAP: d.rd_data = sw_snapshot_value;
            cgs_pkg::OFS_HW_SNAP: d.rd_data = hw_snapshot_reg;
            cgs_pkg::OFS_CONTROL: d.rd_data = {24'h000000, q.dma_irq_en, q.tc_irq_en, q.arm,
                                               q.gate_invert_ctl, q.gate_interpret_sel,
                                               q.dma_transfer_en, q.save_follow_ctl};
            default:              d.rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         q <= '0;
      else
         q <= d;
   end

   // ----------------------------------------------------------------------
   // Snapshot registers
   // ----------------------------------------------------------------------
   cgs_save_regs u_save (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_value    (q.count),
      .i_track    (track && !q.dma_transfer_en),
      .i_freeze   (freeze && !q.dma_transfer_en),
      .i_dma_en   (q.dma_transfer_en), // RULE_16
      .i_dma_save (save_evt),
      .o_sw       (sw_snapshot_value),
      .o_hw       (hw_snapshot_reg)
   );

   assign o_rd_data             = q.rd_data;
   assign o_counter_irq_flag    = q.irq;
   assign o_terminal_count_flag = q.terminal_count_flag;
   assign o_eff_gate            = q.eff_gate;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence seq_sec_assert;
      src_edge && q.combined_gate_enable && sec_rise && !prim_rise;
   endsequence

   sequence seq_prim_assert;
      src_edge && prim_rise;
   endsequence

   AST_SEL_LOW: assert property ( // RULE_07
      q.second_gate_source_sel == cgs_pkg::SEL_LOW |-> sec_gate == q.second_gate_invert)
      else $error("Code 31 second gate is not constant low.");

   AST_SEL_UPDOWN: assert property ( // RULE_04
      q.second_gate_source_sel == cgs_pkg::SEL_UPDOWN_0 |-> sec_gate == (pins_s[2] ^ q.second_gate_invert))
      else $error("Code 2 does not select up/down pin 0.");

   AST_COMB_SET: assert property ( // RULE_08
      seq_sec_assert |=> q.comb_gate ##1 (q.comb_gate || $past(prim_rise)))
      else $error("Second gate assertion did not assert the combined gate.");

   AST_COMB_CLR: assert property ( // RULE_08
      seq_prim_assert |=> !q.comb_gate)
      else $error("Primary gate assertion did not deassert the combined gate.");

   AST_PRIMARY_ONLY: assert property ( // RULE_20
      !q.combined_gate_enable |-> gate == prim_gate)
      else $error("Gate differs from primary gate outside combined mode.");

   AST_TC_SET: assert property ( // RULE_12
      tc_hit |=> o_terminal_count_flag ##1 (o_terminal_count_flag || $past(tc_ack)))
      else $error("Terminal count flag not set or lost.");

   AST_TC_ACK: assert property ( // RULE_13
      tc_ack && !tc_hit |=> !o_terminal_count_flag)
      else $error("Acknowledge did not clear terminal count flag.");

   AST_IRQ: assert property ( // RULE_11
      o_counter_irq_flag == ((q.terminal_count_flag && q.tc_irq_en) || (q.dma_flag && q.dma_irq_en)))
      else $error("Interrupt status does not match enabled conditions.");

   AST_TRACK: assert property ( // RULE_15
      !q.save_follow_ctl && !q.dma_transfer_en |=> sw_snapshot_value == $past(q.count))
      else $error("Snapshot does not track the live count.");

   AST_FREEZE: assert property ( // RULE_14
      q.save_follow_ctl && !q.save_pend && !q.dma_transfer_en |=> $stable(sw_snapshot_value))
      else $error("Frozen snapshot changed.");

   AST_LEVEL_RUN: assert property ( // RULE_09
      src_edge && q.arm && q.gate_interpret_sel == cgs_pkg::MODE_LEVEL && gate |=>
      q.count == $past(q.count) + 32'h0000_0001)
      else $error("Level gating did not count with gate high.");

endmodule // cgs_counter
`default_nettype wire

// file: tb/cgs_far_side.sv
// Far-side model of the counter's pins: source, gate and candidate lines.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/100ps
`default_nettype none
module cgs_far_side (
   input  wire logic       i_clk,
   output var  logic       o_src,
   output var  logic       o_ud,
   output var  logic [7:0] o_ud_bus,
   output var  logic       o_nsrc,
   output var  logic [6:0] o_trig,
   output var  logic       o_nout,
   output var  logic       o_gate
);
   initial {o_src, o_ud, o_ud_bus, o_nsrc, o_trig, o_nout, o_gate} = 20'h0;
   // -----------------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------------
   // One source edge, slow enough to clear the pin synchroniser.
   task automatic src_edge();
      @(posedge i_clk) o_src <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_src <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic gate(input logic lvl);
      @(posedge i_clk) o_gate <= lvl;
   endtask
   // Drives the line that second gate select codes 1 to 17 and 20 pick.
   task automatic put(input logic [4:0] c, input logic lvl);
      @(posedge i_clk);
      if (c == 5'h01) o_ud <= lvl;
      else if (c <= 5'h09) o_ud_bus[c - 5'h02] <= lvl;
      else if (c == 5'h0a) o_nsrc <= lvl;
      else if (c <= 5'h11) o_trig[c - 5'h0b] <= lvl;
      else o_nout <= lvl;
   endtask
endmodule // cgs_far_side
`default_nettype wire

// file: tb/cgs_counter_tb_top.sv
// Self-checking bench of the counter block.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module cgs_counter_tb_top;
   logic i_clk = 1'b0, i_rst = 1'b1, wr_en, rd_en;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, v, h;
   logic src, ud, nsrc, nout, gt, irq, tc, eff;
   logic [7:0] ud_bus;
   logic [6:0] trig;
   int fails = 0, check_count = 0;
   initial forever #50 i_clk = ~i_clk;
   cgs_far_side far (.i_clk(i_clk), .o_src(src), .o_ud(ud), .o_ud_bus(ud_bus), .o_nsrc(nsrc),
      .o_trig(trig), .o_nout(nout), .o_gate(gt));
   cgs_counter dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .o_rd_data(rdata), .i_src_pin(src), .i_updown_pin(ud), .i_updown_bus(ud_bus),
      .i_neighbour_source(nsrc), .i_trigger_bus_line(trig), .i_neighbour_out(nout), .i_gate_pin(gt),
      .o_counter_irq_flag(irq), .o_terminal_count_flag(tc), .o_eff_gate(eff));
   // -----------------------------------------------------------------
   // Register port and run control
   // -----------------------------------------------------------------
   task automatic reset();
      @(posedge i_clk) i_rst <= 1'b1;
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge i_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge i_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_regs();
      wr(4'h1, 32'hffff);
      for (int a = 0; a < 7; a++)
      begin
         rd(a[3:0], v);
         `CHK("reset read", 32'h0, v)
      end
      @(posedge i_clk);
      #1 `CHK("idle read data", 32'h0, rdata)
      `CHK("tc flag", 1'b0, tc)
      $display("test regs done");
   endtask
   task automatic t_track();
      wr(4'h3, 32'h20);
      repeat (3) far.src_edge();
      rd(4'h2, v);
      `CHK("tracked count", 32'h3, v)
      wr(4'h3, 32'h21);
      far.src_edge();
      rd(4'h2, v);
      repeat (2) far.src_edge();
      rd(4'h2, h);
      `CHK("frozen held", v, h)
      `CHK("frozen value", 1'b1, v == 32'h3 || v == 32'h4)
      $display("test snapshot done");
   endtask
   task automatic t_comb(input logic [4:0] c);
      wr(4'h0, {18'h0, c[0], 1'b0, c, 6'h0, 1'b1});
      far.put(c, c[0]);
      far.src_edge();
      far.put(c, ~c[0]);
      far.src_edge();
      `CHK("second gate asserts", 1'b1, eff)
      far.gate(1'b1);
      far.src_edge();
      `CHK("primary deasserts", 1'b0, eff)
      far.gate(1'b0);
   endtask
   task automatic t_direct();
      wr(4'h0, 32'h500);
      far.gate(1'b1);
      far.src_edge();
      `CHK("primary passes", 1'b1, eff)
      far.put(5'h0a, 1'b0);
      far.gate(1'b0);
      far.src_edge();
      `CHK("primary low", 1'b0, eff)
      $display("test direct gate done");
   endtask
   task automatic t_pulse();
      wr(4'h0, 32'h2f01);
      wr(4'h3, 32'h10);
      far.src_edge();
      `CHK("pulse idle", 1'b0, eff)
      far.gate(1'b1);
      far.src_edge();
      `CHK("pulse start", 1'b1, eff)
      far.gate(1'b0);
      far.src_edge();
      `CHK("pulse stop", 1'b0, eff)
      wr(4'h0, 32'h0f81);
      far.gate(1'b1);
      far.src_edge();
      `CHK("constant low gate", 1'b0, eff)
      far.gate(1'b0);
      $display("test pulse setup done");
   endtask
   task automatic t_dma();
      reset();
      far.gate(1'b1);
      far.src_edge();
      wr(4'h3, 32'ha6);
      repeat (2) far.src_edge();
      far.gate(1'b0);
      far.src_edge();
      rd(4'h5, h);
      `CHK("counted at once", 1'b1, h != 32'h0)
      rd(4'h1, v);
      `CHK("irq status", 32'h8000, v)
      `CHK("irq pin", 1'b1, irq)
      far.gate(1'b1);
      repeat (3) far.src_edge();
      far.gate(1'b0);
      far.src_edge();
      rd(4'h2, v);
      `CHK("alternate save", h + 32'h3, v)
      wr(4'h4, 32'h3);
      rd(4'h1, v);
      `CHK("acked status", 32'h0, v)
      $display("test dma done");
   endtask
   initial
   begin
      #1_000_000;
      fails++;
      wrap_up();
   end
   initial
   begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      addr <= 4'h0;
      wdata <= 32'h0;
      reset();
      t_regs();
      t_track();
      for (int i = 1; i <= 20; i++)
         if (i != 18 && i != 19) t_comb(i[4:0]);
      $display("test combined gate done");
      t_direct();
      t_pulse();
      t_dma();
      wrap_up();
   end
endmodule // cgs_counter_tb_top
`default_nettype wire
